// [shared/tflc_pkg.sv]
// constants, types and register map of the tray feed and lift controller
// assumes a 100 MHz system clock and three identical trays
package tflc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int FILT_NS = 160;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_W = 5;
  localparam int SOL_LEAD_NS = 20000;
  localparam int SOL_CYC = (SOL_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 20000;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 12;
  localparam longint LOWER_MS = 2000;
  localparam longint LOWER_CYC_DEF = LOWER_MS * 1000000 / CLK_NS;
  localparam int LOW_W = 32;

  // ****************************************
  // sizes and register map
  // ****************************************
  localparam int TRAYS = 3;
  localparam int SENSE_W = 12;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_OPSIZE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_SIZE = 8'h10;
  localparam int LANE_W = 8;
  localparam int CTRL_REGION_BIT = 8;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TYPE_LSB = 4;
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_NEAR_BIT = 2;
  localparam int STAT_EMPTY_BIT = 3;
  localparam int STAT_LIFT_BIT = 4;
  localparam int STAT_FEED_BIT = 5;
  localparam logic [2:0] FEED_REQ_RST = 3'h0;
  localparam logic REGION_RST = 1'b0;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    ASSIST_AUTO = 2'h0,
    ASSIST_ON = 2'h1,
    ASSIST_OFF = 2'h2
  } tflc_assist_t;
  localparam logic [1:0] MODE_RST = ASSIST_AUTO;

  typedef enum logic [3:0] {
    PT_PLAIN = 4'h0, PT_THIN = 4'h1, PT_THICK1 = 4'h2, PT_THICK2 = 4'h3,
    PT_THICK3 = 4'h4, PT_SPECIAL1 = 4'h5, PT_SPECIAL2 = 4'h6,
    PT_SPECIAL3 = 4'h7, PT_COATED1 = 4'h8, PT_COATED2 = 4'h9,
    PT_COATED3 = 4'ha
  } tflc_ptype_t;
  localparam logic [3:0] PTYPE_RST = PT_PLAIN;

  typedef enum logic [4:0] {
    SZ_NONE = 5'h00, SZ_12X18 = 5'h01, SZ_13X19 = 5'h02, SZ_320X450 = 5'h03,
    SZ_A3_SEF = 5'h04, SZ_A4_LEF = 5'h05, SZ_DLT_SEF = 5'h06,
    SZ_LT_LEF = 5'h07, SZ_B4_SEF = 5'h08, SZ_B5_LEF = 5'h09,
    SZ_A4_SEF = 5'h0a, SZ_LT_SEF = 5'h0b, SZ_A5_LEF = 5'h0c,
    SZ_HLT_LEF = 5'h0d, SZ_B5_SEF = 5'h0e, SZ_F_SEF = 5'h0f,
    SZ_A5_SEF = 5'h10, SZ_HLT_SEF = 5'h11
  } tflc_size_t;
  localparam logic [4:0] OPSIZE_RST = SZ_NONE;

  typedef enum logic [1:0] {
    LV_100 = 2'h0, LV_75 = 2'h1, LV_50 = 2'h2, LV_25 = 2'h3
  } tflc_level_t;

  typedef enum logic [2:0] {
    FS_IDLE = 3'h0, FS_SOL = 3'h1, FS_PICK = 3'h3, FS_HOLD = 3'h2,
    FS_CARRY = 3'h6
  } tflc_feed_st_t;

  typedef enum logic [2:0] {
    LS_IDLE = 3'h0, LS_UP = 3'h1, LS_READY = 3'h3, LS_DOWN = 3'h2,
    LS_EMPTY = 3'h6
  } tflc_lift_st_t;

  // ****************************************
  // carriers
  // ****************************************
  // height[0] is the near-end sensor; width and length are H=1, L=0
  typedef struct packed {
    logic tray_present;
    logic lift_act;
    logic feed_sense;
    logic end_light;
    logic [3:0] height;
    logic width_sense_a;
    logic width_sense_b;
    logic width_sense_c;
    logic length_sense;
  } tflc_sense_t;

  typedef struct packed {
    logic feed_mot;
    logic grip_mot;
    logic pickup_sol;
    logic lift_up;
    logic lift_down;
    logic fan;
  } tflc_drive_t;

endpackage : tflc_pkg

// [core/tflc_filter.sv]
// input synchroniser and bounce filter for all tray sensors
// assumes raw pins are asynchronous to clk_sys
`timescale 1ns/100ps
module tflc_filter (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [tflc_pkg::TRAYS*tflc_pkg::SENSE_W-1:0] raw,
  output logic [tflc_pkg::TRAYS*tflc_pkg::SENSE_W-1:0] clean
);

  localparam int N = tflc_pkg::TRAYS * tflc_pkg::SENSE_W;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] out;
    logic [N-1:0][tflc_pkg::FILT_W-1:0] cnt;
  } tflc_filt_st_t;

  tflc_filt_st_t st_q;
  tflc_filt_st_t st_d;

  // ****************************************
  // filter
  // ****************************************
  // output follows only after FILT_CYC equal samples in a row
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    for (int i = 0; i < N; i++)
    begin
      if (st_q.s2[i] == st_q.out[i])
        st_d.cnt[i] = '0;
      else if (st_q.cnt[i] == tflc_pkg::FILT_W'(tflc_pkg::FILT_CYC - 1))
      begin
        st_d.out[i] = st_q.s2[i]; // R18
        st_d.cnt[i] = '0;
      end
      else
        st_d.cnt[i] = st_q.cnt[i] + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign clean = st_q.out;

  AST_FILTER_SETTLE: assert property (@(posedge clk_sys) disable iff (srst) // R18
    $changed(st_q.out[0]) |->
      $past(st_q.cnt[0]) == tflc_pkg::FILT_W'(tflc_pkg::FILT_CYC - 1))
    else $error("sensor output changed before the filter settled");

endmodule : tflc_filter

// [core/tflc_ctrl.sv]
// feed, pick-up and lift sequencing for three paper trays
// assumes sensor pins asynchronous; register port on clk_sys
//
// Summary of operation
// R1 - tray selected: feed and grip motors on
// R2 - solenoid energised before feed motor starts
// R3 - per-tray assist mode: auto, on, off
// R4 - auto assist follows selected paper type
// R5 - fans only for eligible thick/special/coated types
// R6 - feed sensor leading edge stops feed motor
// R7 - assist on: roller stays down, then refeed
// R8 - assist off: roller raised, then refeed
// R9 - tray inserted: lift motor runs forward
// R10 - lift motor running: solenoid energised
// R11 - lift sensor release stops lift motor
// R12 - lift sensor active again: lift resumes
// R13 - decode size from width/length sensors
// R14 - ambiguous sizes take operator-set size
// R15 - remaining level from height sensors 4,3,2
// R16 - near-end: sensor 1 on, sensor 2 off
// R17 - paper end: flag empty, lower 2 s
// R18 - debounce every sensor before use
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module tflc_ctrl #(
  parameter logic [31:0] LOWER_CYC = 32'(tflc_pkg::LOWER_CYC_DEF)
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire tflc_pkg::tflc_sense_t [2:0] sense,
  output tflc_pkg::tflc_drive_t [2:0] drive
);

  typedef struct packed {
    tflc_pkg::tflc_feed_st_t [2:0] fst;
    tflc_pkg::tflc_lift_st_t [2:0] lst;
    logic [2:0][tflc_pkg::TMR_W-1:0] tmr;
    logic [2:0][tflc_pkg::LOW_W-1:0] low_cnt;
    logic [2:0] lift_prev;
    logic [2:0] pres_prev;
    logic [2:0] empty;
    logic [2:0] feed_req;
    logic region;
    logic [2:0][1:0] mode;
    logic [2:0][3:0] ptype;
    logic [2:0][4:0] opsize;
    logic [31:0] rdata;
  } tflc_ctrl_st_t;

  tflc_ctrl_st_t st_q;
  tflc_ctrl_st_t st_d;
  tflc_pkg::tflc_sense_t [2:0] sf;
  logic [2:0] type_ok;
  logic [2:0] assist;
  logic [2:0] near;
  tflc_pkg::tflc_level_t [2:0] level;
  tflc_pkg::tflc_size_t [2:0] rep_size;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic f_type_ok(input logic [3:0] pt);
    f_type_ok = pt inside {tflc_pkg::PT_THICK2, tflc_pkg::PT_THICK3,
      tflc_pkg::PT_SPECIAL2, tflc_pkg::PT_COATED1, tflc_pkg::PT_COATED2,
      tflc_pkg::PT_COATED3};
  endfunction : f_type_ok

  // patterns a region cannot tell apart report nothing on their own
  function automatic tflc_pkg::tflc_size_t f_auto_size(
    input logic [3:0] pat,
    input logic eu
  );
    case (pat)
      4'h1: f_auto_size = tflc_pkg::SZ_12X18;
      4'h3: f_auto_size = tflc_pkg::SZ_A3_SEF;
      4'h2: f_auto_size = tflc_pkg::SZ_A4_LEF;
      4'h5: f_auto_size = tflc_pkg::SZ_DLT_SEF;
      4'h4: f_auto_size = tflc_pkg::SZ_LT_LEF;
      4'h7: f_auto_size = tflc_pkg::SZ_B4_SEF;
      4'h6: f_auto_size = tflc_pkg::SZ_B5_LEF;
      4'h9: f_auto_size = eu ? tflc_pkg::SZ_A4_SEF : tflc_pkg::SZ_LT_SEF;
      4'h8: f_auto_size = eu ? tflc_pkg::SZ_A5_LEF : tflc_pkg::SZ_HLT_LEF;
      4'hb: f_auto_size = tflc_pkg::SZ_F_SEF;
      4'hc: f_auto_size = tflc_pkg::SZ_A5_SEF;
      4'he: f_auto_size = tflc_pkg::SZ_HLT_SEF;
      default: f_auto_size = tflc_pkg::SZ_NONE;
    endcase
  endfunction : f_auto_size

  function automatic tflc_pkg::tflc_level_t f_level(input logic [3:0] h);
    if (h[1])
      f_level = tflc_pkg::LV_25;
    else if (h[2])
      f_level = tflc_pkg::LV_50;
    else if (h[3])
      f_level = tflc_pkg::LV_75;
    else
      f_level = tflc_pkg::LV_100;
  endfunction : f_level

  tflc_filter u_filter (
    .clk_sys(clk_sys),
    .srst(srst),
    .raw(sense),
    .clean(sf)
  );

  // ****************************************
  // sequencing and registers
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = '0;
    for (int t = 0; t < tflc_pkg::TRAYS; t++)
    begin
      st_d.lift_prev[t] = sf[t].lift_act;
      st_d.pres_prev[t] = sf[t].tray_present;
      case (st_q.lst[t])
        tflc_pkg::LS_IDLE:
          if (sf[t].tray_present && !st_q.pres_prev[t])
            st_d.lst[t] = tflc_pkg::LS_UP; // R9
        tflc_pkg::LS_UP:
          if (st_q.lift_prev[t] && !sf[t].lift_act)
            st_d.lst[t] = tflc_pkg::LS_READY; // R11
        tflc_pkg::LS_READY:
          if (!sf[t].end_light)
          begin
            st_d.lst[t] = tflc_pkg::LS_DOWN; // R17
            st_d.empty[t] = 1'b1;
            st_d.low_cnt[t] = '0;
          end
          else if (sf[t].lift_act)
            st_d.lst[t] = tflc_pkg::LS_UP; // R12
        tflc_pkg::LS_DOWN:
          if (st_q.low_cnt[t] == LOWER_CYC - 32'h1)
            st_d.lst[t] = tflc_pkg::LS_EMPTY; // R17
          else
            st_d.low_cnt[t] = st_q.low_cnt[t] + 1'b1;
        tflc_pkg::LS_EMPTY:
          st_d.empty[t] = 1'b1;
        default:
          st_d.lst[t] = tflc_pkg::LS_IDLE;
      endcase
      // pulling the tray ends everything; empty clears only here
      if (!sf[t].tray_present)
      begin
        st_d.lst[t] = tflc_pkg::LS_IDLE;
        st_d.empty[t] = 1'b0;
      end

      case (st_q.fst[t])
        tflc_pkg::FS_IDLE:
          if (st_q.feed_req[t] && st_q.lst[t] == tflc_pkg::LS_READY)
          begin
            st_d.fst[t] = tflc_pkg::FS_SOL; // R2
            st_d.tmr[t] = '0;
          end
        tflc_pkg::FS_SOL:
          if (!st_q.feed_req[t])
            st_d.fst[t] = tflc_pkg::FS_IDLE;
          else if (st_q.tmr[t] == tflc_pkg::TMR_W'(tflc_pkg::SOL_CYC - 1))
            st_d.fst[t] = tflc_pkg::FS_PICK; // R2
          else
            st_d.tmr[t] = st_q.tmr[t] + 1'b1;
        tflc_pkg::FS_PICK:
          if (sf[t].feed_sense)
          begin
            st_d.fst[t] = tflc_pkg::FS_HOLD; // R6
            st_d.tmr[t] = '0;
          end
        tflc_pkg::FS_HOLD:
          if (st_q.tmr[t] == tflc_pkg::TMR_W'(tflc_pkg::HOLD_CYC - 1))
            st_d.fst[t] = tflc_pkg::FS_CARRY; // R7
          else
            st_d.tmr[t] = st_q.tmr[t] + 1'b1;
        tflc_pkg::FS_CARRY:
          if (!sf[t].feed_sense)
          begin
            st_d.fst[t] = st_q.feed_req[t] ? tflc_pkg::FS_SOL
                                           : tflc_pkg::FS_IDLE;
            st_d.tmr[t] = '0;
          end
        default:
          st_d.fst[t] = tflc_pkg::FS_IDLE;
      endcase
      // an empty or lowering tray stops feeding one cycle after lowering starts
      if (!sf[t].tray_present || st_q.lst[t] == tflc_pkg::LS_DOWN ||
          st_q.lst[t] == tflc_pkg::LS_EMPTY)
        st_d.fst[t] = tflc_pkg::FS_IDLE;
    end

    if (wr_stb)
    begin
      case (addr)
        tflc_pkg::REG_CTRL:
        begin
          st_d.feed_req = wdata[2:0]; // R1
          st_d.region = wdata[tflc_pkg::CTRL_REGION_BIT];
        end
        tflc_pkg::REG_CFG:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
          begin
            st_d.mode[t] =
              wdata[t*tflc_pkg::LANE_W+tflc_pkg::CFG_MODE_LSB +: 2]; // R3
            st_d.ptype[t] =
              wdata[t*tflc_pkg::LANE_W+tflc_pkg::CFG_TYPE_LSB +: 4];
          end
        tflc_pkg::REG_OPSIZE:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
            st_d.opsize[t] = wdata[t*tflc_pkg::LANE_W +: 5]; // R14
        default:
          st_d.region = st_q.region;
      endcase
    end

    if (rd_stb)
    begin
      case (addr)
        tflc_pkg::REG_CTRL:
        begin
          st_d.rdata[2:0] = st_q.feed_req;
          st_d.rdata[tflc_pkg::CTRL_REGION_BIT] = st_q.region;
        end
        tflc_pkg::REG_CFG:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
          begin
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::CFG_MODE_LSB +: 2] =
              st_q.mode[t];
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::CFG_TYPE_LSB +: 4] =
              st_q.ptype[t];
          end
        tflc_pkg::REG_OPSIZE:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
            st_d.rdata[t*tflc_pkg::LANE_W +: 5] = st_q.opsize[t];
        tflc_pkg::REG_STATUS:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
          begin
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::STAT_LEVEL_LSB +: 2] =
              level[t];
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::STAT_NEAR_BIT] = near[t];
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::STAT_EMPTY_BIT] =
              st_q.empty[t];
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::STAT_LIFT_BIT] =
              st_q.lst[t] == tflc_pkg::LS_UP ||
              st_q.lst[t] == tflc_pkg::LS_DOWN;
            st_d.rdata[t*tflc_pkg::LANE_W+tflc_pkg::STAT_FEED_BIT] =
              st_q.fst[t] != tflc_pkg::FS_IDLE;
          end
        tflc_pkg::REG_SIZE:
          for (int t = 0; t < tflc_pkg::TRAYS; t++)
            st_d.rdata[t*tflc_pkg::LANE_W +: 5] = rep_size[t];
        default:
          st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= '0;
      st_q.feed_req <= tflc_pkg::FEED_REQ_RST;
      st_q.region <= tflc_pkg::REGION_RST;
      st_q.mode <= {3{tflc_pkg::MODE_RST}}; // R3
      st_q.ptype <= {3{tflc_pkg::PTYPE_RST}};
      st_q.opsize <= {3{tflc_pkg::OPSIZE_RST}};
    end
    else
      st_q <= st_d;
  end

  assign rdata = st_q.rdata;

  // ****************************************
  // per-tray outputs and checks
  // ****************************************
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  for (genvar t = 0; t < tflc_pkg::TRAYS; t++)
  begin : g_tray
    logic hold_or_carry;
    assign hold_or_carry = st_q.fst[t] == tflc_pkg::FS_HOLD ||
                           st_q.fst[t] == tflc_pkg::FS_CARRY;
    assign type_ok[t] = f_type_ok(st_q.ptype[t]); // R5
    // mode 3 is unused and behaves as auto
    assign assist[t] = st_q.mode[t] == tflc_pkg::ASSIST_ON ||
      (st_q.mode[t] != tflc_pkg::ASSIST_OFF && type_ok[t]); // R4
    assign level[t] = f_level(sf[t].height); // R15
    assign near[t] = sf[t].height[0] && !sf[t].height[1]; // R16
    assign rep_size[t] = st_q.opsize[t] != tflc_pkg::SZ_NONE ? // R14
      tflc_pkg::tflc_size_t'(st_q.opsize[t]) :
      f_auto_size({sf[t].width_sense_a, sf[t].width_sense_b,
                   sf[t].width_sense_c, sf[t].length_sense},
                  st_q.region); // R13
    assign drive[t].grip_mot = st_q.fst[t] != tflc_pkg::FS_IDLE; // R1
    assign drive[t].feed_mot = st_q.fst[t] == tflc_pkg::FS_PICK ||
                               st_q.fst[t] == tflc_pkg::FS_CARRY; // R1
    // lift running overrides a raised roller
    assign drive[t].pickup_sol = st_q.fst[t] == tflc_pkg::FS_SOL || // R2
      st_q.fst[t] == tflc_pkg::FS_PICK ||
      (hold_or_carry && assist[t]) || // R8
      st_q.lst[t] == tflc_pkg::LS_UP; // R10
    assign drive[t].lift_up = st_q.lst[t] == tflc_pkg::LS_UP;
    assign drive[t].lift_down = st_q.lst[t] == tflc_pkg::LS_DOWN;
    assign drive[t].fan = st_q.fst[t] != tflc_pkg::FS_IDLE &&
                          assist[t] && type_ok[t]; // R5

    AST_GRIP_WITH_FEED: assert property ( // R1
      drive[t].feed_mot |-> drive[t].grip_mot)
      else $error("feed motor on without grip motor");
    AST_MODE_RESET: assert property ( // R3
      $fell(srst) |-> st_q.mode[t] == tflc_pkg::ASSIST_AUTO)
      else $error("assist mode not auto after reset");
    AST_SOL_LEADS: assert property ( // R2
      $rose(drive[t].feed_mot) && st_q.fst[t] == tflc_pkg::FS_PICK |->
        $past(drive[t].pickup_sol) && $past(drive[t].pickup_sol, 2))
      else $error("feed motor started before solenoid");
    AST_FAN_TYPE: assert property ( // R5
      drive[t].fan |-> type_ok[t] && st_q.fst[t] != tflc_pkg::FS_IDLE)
      else $error("fan on for ineligible paper");
    AST_EDGE_STOP: assert property ( // R6
      st_q.fst[t] == tflc_pkg::FS_PICK && sf[t].feed_sense |=>
        !drive[t].feed_mot ##1 !drive[t].feed_mot)
      else $error("feed motor not stopped at leading edge");
    AST_HOLD_DOWN: assert property ( // R7
      st_q.fst[t] == tflc_pkg::FS_HOLD && assist[t] |-> drive[t].pickup_sol)
      else $error("roller raised with assist active");
    AST_HOLD_UP: assert property ( // R8
      hold_or_carry && !assist[t] && !drive[t].lift_up |->
        !drive[t].pickup_sol)
      else $error("roller lowered with assist inactive");
    AST_LIFT_INSERT: assert property ( // R9
      $rose(sf[t].tray_present) |=> drive[t].lift_up)
      else $error("lift not started on tray insertion");
    AST_LIFT_SOL: assert property ( // R10
      drive[t].lift_up |-> drive[t].pickup_sol)
      else $error("lift running without solenoid");
    AST_LIFT_STOP: assert property ( // R11
      drive[t].lift_up && $fell(sf[t].lift_act) && sf[t].tray_present |=>
        !drive[t].lift_up)
      else $error("lift not stopped at feed height");
    AST_LIFT_RESUME: assert property ( // R12
      st_q.lst[t] == tflc_pkg::LS_READY && sf[t].lift_act &&
        sf[t].end_light && sf[t].tray_present |=> drive[t].lift_up)
      else $error("lift not resumed when stack dropped");
    AST_SIZE_A3: assert property ( // R13
      st_q.opsize[t] == 5'h00 && {sf[t].width_sense_a, sf[t].width_sense_b,
        sf[t].width_sense_c, sf[t].length_sense} == 4'h3 |->
        rep_size[t] == tflc_pkg::SZ_A3_SEF)
      else $error("pattern LLHH not decoded as A3");
    AST_SIZE_REGION: assert property ( // R14
      st_q.opsize[t] == 5'h00 && !st_q.region && {sf[t].width_sense_a,
        sf[t].width_sense_b, sf[t].width_sense_c,
        sf[t].length_sense} == 4'h9 |->
        rep_size[t] == tflc_pkg::SZ_LT_SEF)
      else $error("shared pattern not resolved by region");
    AST_LEVEL_25: assert property ( // R15
      sf[t].height[1] |-> level[t] == tflc_pkg::LV_25 && !near[t])
      else $error("level wrong past height sensor 2");
    AST_EMPTY_LOWER: assert property ( // R17
      $rose(drive[t].lift_down) |->
        (st_q.empty[t] && drive[t].lift_down && !drive[t].feed_mot)[*8])
      else $error("empty tray not lowered");
  end : g_tray

endmodule : tflc_ctrl

// [sim/tflc_tray_model.sv]
// one paper tray: stack, lift gap, feed sensor and fixed sensor levels
// assumes drives are levels that the controller holds per state
`timescale 1ns/100ps
module tflc_tray_model (
  input wire logic clk_sys,
  input wire logic present,
  input wire logic out_paper,
  input wire logic drop,
  input wire logic [3:0] heights,
  input wire logic [3:0] size_pat,
  input wire tflc_pkg::tflc_drive_t drv,
  output tflc_pkg::tflc_sense_t sense
);
  logic [3:0] gap_q = 4'h6;
  logic [5:0] run_q = 6'h00;
  logic sheet_q = 1'b0;

  // stack sinks on drop, rises one step a cycle while lifting
  always @(posedge clk_sys)
  begin
    if (drop)
      gap_q <= 4'h4;
    else if (!present)
      gap_q <= 4'h6;
    else if (drv.lift_up && gap_q != 4'h0)
      gap_q <= gap_q - 4'h1;
  end

  // sheet edge reaches or leaves the sensor after 41 motor cycles
  always @(posedge clk_sys)
  begin
    if (!drv.feed_mot)
      run_q <= 6'h00;
    else if (run_q == 6'h28)
    begin
      run_q <= 6'h00;
      sheet_q <= ~sheet_q;
    end
    else
      run_q <= run_q + 6'h01;
  end

  always_comb
  begin
    sense.tray_present = present;
    sense.lift_act = present && gap_q != 4'h0;
    sense.feed_sense = sheet_q;
    sense.end_light = present && !out_paper;
    sense.height = heights;
    {sense.width_sense_a, sense.width_sense_b, sense.width_sense_c,
      sense.length_sense} = size_pat;
  end
endmodule : tflc_tray_model

// [sim/tray_feed_lift_controller_test.sv]
// self-checking bench: three tray models around the controller
// assumes lowering shortened to 50 cycles; sensors settle in 20 cycles
`timescale 1ns/100ps
module tray_feed_lift_controller_test;
  localparam logic [31:0] LOW_N = 32'h32;
  localparam int FD = 5, GR = 4, SO = 3, LU = 2, LD = 1, FA = 0;
  localparam logic [3:0] PATS [12] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h7,
    4'h6, 4'h9, 4'h8, 4'hb, 4'hc, 4'he, 4'h1};
  localparam logic [4:0] SZ_NA [12] = '{5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0b, 5'h0d, 5'h0f, 5'h10, 5'h11, 5'h01};
  localparam logic [4:0] SZ_EU [12] = '{5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0f, 5'h10, 5'h11, 5'h01};
  localparam logic [3:0] HTS [7] = '{4'h0, 4'h8, 4'hc, 4'he, 4'h1,
    4'hd, 4'h3};
  localparam logic [31:0] LVX [7] = '{32'h0, 32'h1, 32'h2, 32'h3,
    32'h4, 32'h6, 32'h3};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  tflc_pkg::tflc_sense_t [2:0] sense;
  tflc_pkg::tflc_drive_t [2:0] drive;
  logic [2:0] present = 3'h0;
  logic [2:0] out_paper = 3'h0;
  logic [2:0] drop = 3'h0;
  logic [3:0] heights = 4'h0;
  logic [3:0] size_pat = 4'hf;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  tflc_ctrl #(.LOWER_CYC(LOW_N)) i_dut (.clk_sys(clk_sys), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .sense(sense), .drive(drive));

  for (genvar t = 0; t < 3; t++)
  begin : g_tray
    tflc_tray_model i_tray (.clk_sys(clk_sys), .present(present[t]),
      .out_paper(out_paper[t]), .drop(drop[t]), .heights(heights),
      .size_pat(size_pat), .drv(drive[t]), .sense(sense[t]));
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // a full feed run is about 25k cycles; hang guard well above
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rd

  task wait_drv(input int t, input int f, input logic v, input int lim);
    n = 0;
    while (drive[t][f] !== v && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(drive[t][f]), 32'(v));
  endtask : wait_drv

  task settle;
    repeat (25) @(posedge clk_sys);
  endtask : settle

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rd(tflc_pkg::REG_CTRL, 32'hffffffff, 32'h0);
    rd(tflc_pkg::REG_CFG, 32'hffffffff, 32'h0);
    rd(tflc_pkg::REG_OPSIZE, 32'hffffffff, 32'h0);
    rd(8'h14, 32'hffffffff, 32'h0);
    chk(32'(drive), 32'h0);
    $display("reset test done");
  endtask : t_reset

  task t_lift;
    present <= 3'h7;
    for (int t = 0; t < 3; t++)
    begin
      wait_drv(t, LU, 1'b1, 40);
      chk(32'(drive[t][SO]), 32'h1);
    end
    for (int t = 0; t < 3; t++)
      wait_drv(t, LU, 1'b0, 60);
    chk(32'(sense[0].lift_act), 32'h0);
    $display("lift test done");
  endtask : t_lift

  task t_size;
    for (int r = 0; r < 2; r++)
    begin
      wr(tflc_pkg::REG_CTRL, 32'(r) << 8);
      for (int i = 0; i < 12; i++)
      begin
        size_pat <= PATS[i];
        settle;
        rd(tflc_pkg::REG_SIZE, 32'h1f, r ? SZ_EU[i] : SZ_NA[i]);
      end
    end
    size_pat <= 4'hd;
    settle;
    rd(tflc_pkg::REG_SIZE, 32'h1f, 32'h0);
    wr(tflc_pkg::REG_OPSIZE, 32'h0e);
    rd(tflc_pkg::REG_SIZE, 32'h1f, 32'h0e);
    wr(tflc_pkg::REG_OPSIZE, 32'h0);
    wr(tflc_pkg::REG_CTRL, 32'h0);
    $display("size test done");
  endtask : t_size

  task t_level;
    for (int i = 0; i < 7; i++)
    begin
      heights <= HTS[i];
      settle;
      rd(tflc_pkg::REG_STATUS, 32'h7, LVX[i]);
    end
    heights <= 4'h0;
    $display("level test done");
  endtask : t_level

  task t_feed(input logic [1:0] m, input logic [3:0] p, input logic as,
    input logic fn);
    wr(tflc_pkg::REG_CFG, {24'h0, p, 2'h0, m});
    wr(tflc_pkg::REG_CTRL, 32'h1);
    wait_drv(0, GR, 1'b1, 5);
    chk(32'(drive[0][SO]), 32'h1);
    chk(32'(drive[0][FD]), 32'h0);
    wait_drv(0, FD, 1'b1, tflc_pkg::SOL_CYC + 5);
    chk(32'(n > tflc_pkg::SOL_CYC - 8), 32'h1);
    wait_drv(0, FD, 1'b0, 80);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(32'(drive[0][SO]), 32'(as));
    chk(32'(drive[0][FA]), 32'(fn));
    wait_drv(0, FD, 1'b1, tflc_pkg::HOLD_CYC + 5);
    chk(32'(drive[0][SO]), 32'(as));
    wr(tflc_pkg::REG_CTRL, 32'h0);
    wait_drv(0, FD, 1'b0, 80);
    wait_drv(0, GR, 1'b0, 5);
    $display("feed test mode %0d type %0d done", m, p);
  endtask : t_feed

  task t_drop;
    drop <= 3'h1;
    @(posedge clk_sys);
    drop <= 3'h0;
    wait_drv(0, LU, 1'b1, 40);
    chk(32'(drive[0][SO]), 32'h1);
    wait_drv(0, LU, 1'b0, 60);
    $display("drop test done");
  endtask : t_drop

  task t_empty;
    out_paper <= 3'h1;
    wait_drv(0, LD, 1'b1, 40);
    wait_drv(0, LD, 1'b0, 60);
    chk(32'(n >= LOW_N - 2 && n <= LOW_N + 2), 32'h1);
    rd(tflc_pkg::REG_STATUS, 32'h8, 32'h8);
    repeat (40) @(posedge clk_sys);
    #1;
    chk(32'(drive[0][LU]), 32'h0);
    present <= 3'h6;
    repeat (30) @(posedge clk_sys);
    rd(tflc_pkg::REG_STATUS, 32'h8, 32'h0);
    $display("empty test done");
  endtask : t_empty

  initial
  begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_lift;
    t_size;
    t_level;
    t_feed(2'h0, 4'h3, 1'b1, 1'b1);
    t_feed(2'h2, 4'h3, 1'b0, 1'b0);
    t_feed(2'h1, 4'h0, 1'b1, 1'b0);
    t_feed(2'h0, 4'h0, 1'b0, 1'b0);
    t_feed(2'h0, 4'ha, 1'b1, 1'b1);
    t_feed(2'h0, 4'h7, 1'b0, 1'b0);
    t_drop;
    t_empty;
    wrap_up;
  end
endmodule : tray_feed_lift_controller_test
